// file: src/sram_bus_pkg.sv
// constants and types shared by the synchronous sram bus interface
package sram_bus_pkg;
	// ========================================
	// pin widths
	localparam int ADDR_W = 20;
	localparam int DATA_W = 18;
	localparam int BE_W = 2;
	localparam int LANE_W = 9;
	// ========================================
	// burst and storage
	localparam int BURST_LEN = 4;
	localparam logic [1:0] CNT_ZERO = 2'h0;
	localparam logic [1:0] CNT_ONE = 2'h1;
	localparam int MEM_AW = 4;
	localparam int FIFO_DEPTH = 8;
	// ========================================
	// register map, byte offsets
	localparam logic [7:0] CTRL_OFS = 8'h00;
	localparam logic [7:0] STAT_OFS = 8'h04;
	localparam int CTRL_HOLD_BIT = 0;
	localparam int CTRL_HIZ_BIT = 1;
	localparam int STAT_OP_LSB = 0;
	localparam int STAT_CNT_LSB = 4;
	localparam int STAT_TAP_BIT = 6;
	localparam int STAT_LVL_LSB = 8;
	localparam int STAT_DROP_LSB = 16;
	localparam logic [31:0] WORD_ZERO = 32'h0000_0000;
	localparam logic [7:0] DROP_ZERO = 8'h00;
	localparam logic [1:0] HRESP_OKAY = 2'h0;
	// ========================================
	// operation of the current address cycle
	typedef enum logic [2:0] {
		OP_DESEL = 3'b001,
		OP_READ = 3'b010,
		OP_WRITE = 3'b100
	} op_t;
endpackage

// file: src/sram_bus_if.sv
// sram bus interface: write fifo and device core with register slave
//
// The address map and the AHB-Lite register port were left to the implementer.
`timescale 1ns/100ps
// Overview of operation
// [R1] bursts step only the low two address bits, four words, linear or interleaved
// [R2] advance low ends any burst and loads new address and control
// [R3] read-not-write ignored while bursting; direction fixed at load
// [R4] read-not-write low on a load edge starts a write
// [R5] controller gives byte enables one cycle ahead of write data
// [R6] controller drives valid byte enables on write loads and advances
// [R7] clock enable high makes the edge absent; all state holds; the register slave and TEST_RESET_N still update their state here
// [R8] any chip enable inactive at a load edge starts a deselect cycle
// [R9] data bus goes high impedance one cycle after deselect begins
// [R10] pending read or write still finishes after deselect
// [R11] positive chip enable is active high; all three needed to select
// [R12] test port resets itself at power up; test reset optional
// [R13] read data flows out in the cycle after its load, unregistered
// [R14] controller drives write data the next cycle; captured at its end

// ========================================
// fifo
module sram_wr_fifo #(
	parameter int W = 8,
	parameter int DEPTH = 8
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// fill side
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [W-1:0] in_data,
	// drain side
	output logic out_valid,
	input wire logic out_ready,
	output logic [W-1:0] out_data,
	output logic [$clog2(DEPTH):0] level
);
	localparam int PW = $clog2(DEPTH);
	localparam logic [PW:0] FULL_CNT = (PW+1)'(DEPTH);
	localparam logic [PW-1:0] PTR_ONE = PW'(1);
	localparam logic [PW:0] CNT_STEP = (PW+1)'(1);
	typedef struct packed {
		logic [DEPTH-1:0][W-1:0] mem;
		logic [PW-1:0] wp;
		logic [PW-1:0] rp;
		logic [PW:0] cnt;
	} fifo_t;
	fifo_t s_ff, nxt_s;
	logic push, pop;

	assign in_ready = s_ff.cnt != FULL_CNT;
	assign out_valid = s_ff.cnt != '0;
	assign out_data = s_ff.mem[s_ff.rp];
	assign level = s_ff.cnt;
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;

	always_comb begin
		nxt_s = s_ff;
		if (push) begin
			nxt_s.mem[s_ff.wp] = in_data;
			nxt_s.wp = s_ff.wp + PTR_ONE;
		end
		if (pop)
			nxt_s.rp = s_ff.rp + PTR_ONE;
		if (push && !pop)
			nxt_s.cnt = s_ff.cnt + CNT_STEP;
		else if (pop && !push)
			nxt_s.cnt = s_ff.cnt - CNT_STEP;
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n)
			s_ff <= '0;
		else
			s_ff <= nxt_s;
	end
endmodule

// ========================================
// device core
module sram_bus_if
	import sram_bus_pkg::*;
#(
	parameter int AW = ADDR_W,
	parameter int MAW = MEM_AW,
	parameter int DEPTH = FIFO_DEPTH
) (
	// clock and reset
	input wire logic CLK,
	input wire logic RESETN,
	// address and control pins
	input wire logic [sram_bus_pkg::ADDR_W-1:0] ADDR,
	input wire logic READ_NOT_WRITE,
	input wire logic ADVANCE_NOT_LOAD,
	input wire logic BURST_ORDER_SELECT_N,
	input wire logic CLOCK_ENABLE_N,
	input wire logic [sram_bus_pkg::BE_W-1:0] BYTE_WRITE_ENABLE_N,
	input wire logic CHIP_SELECT_FIRST_N,
	input wire logic CHIP_SELECT_SECOND_N,
	input wire logic CHIP_SELECT_POSITIVE,
	input wire logic OUTPUT_ENABLE_N,
	input wire logic TEST_RESET_N,
	// data bus
	input wire logic [sram_bus_pkg::DATA_W-1:0] DQ_IN,
	output logic [sram_bus_pkg::DATA_W-1:0] DQ_OUT,
	output logic DQ_OE_N,
	output logic WRITE_READY,
	// ahb-lite slave
	input wire logic HSEL,
	input wire logic [31:0] HADDR,
	input wire logic [1:0] HTRANS,
	input wire logic HWRITE,
	input wire logic [2:0] HSIZE,
	input wire logic [31:0] HWDATA,
	input wire logic HREADY,
	output logic HREADYOUT,
	output logic HRESP,
	output logic [31:0] HRDATA
);
	import sram_bus_pkg::*;
	localparam int FW = MAW + BE_W + DATA_W;
	localparam int LW = $clog2(DEPTH) + 1;

	typedef struct packed {
		op_t op;
		logic [AW-1:0] base;
		logic [1:0] cnt;
		logic ilv;
		logic [BE_W-1:0] be_n;
		logic [(1<<MAW)-1:0][DATA_W-1:0] mem;
		logic hold;
		logic hiz;
		logic [7:0] drops;
		logic tap_rst;
		logic dwr;
		logic [7:0] daddr;
		logic [31:0] rdata;
	} core_t;
	core_t s_ff, nxt_s;

	logic selected, run, wr_valid, dr_valid, dr_ready;
	logic [1:0] low;
	logic [MAW-1:0] cur_idx, dr_idx;
	logic [BE_W-1:0] dr_be_n;
	logic [DATA_W-1:0] dr_data;
	logic [LW-1:0] lvl;

	// word offset within the burst
	function automatic logic [1:0] burst_low(input logic [1:0] b,
		input logic [1:0] c, input logic ilv);
		burst_low = ilv ? (b ^ c) : 2'(b + c); // R1
	endfunction

	assign selected = !CHIP_SELECT_FIRST_N && !CHIP_SELECT_SECOND_N
		&& CHIP_SELECT_POSITIVE; // R11
	assign run = !CLOCK_ENABLE_N;
	assign low = burst_low(s_ff.base[1:0], s_ff.cnt, s_ff.ilv);
	assign cur_idx = {s_ff.base[MAW-1:2], low};
	// write data lands one cycle after its address cycle
	assign wr_valid = run && s_ff.op == OP_WRITE; // R10 R14
	assign dr_ready = run && !s_ff.hold;

	sram_wr_fifo #(.W(FW), .DEPTH(DEPTH)) u_fifo (
		.clk(CLK),
		.rst_n(RESETN),
		.in_valid(wr_valid),
		.in_ready(WRITE_READY),
		.in_data({cur_idx, s_ff.be_n, DQ_IN}),
		.out_valid(dr_valid),
		.out_ready(dr_ready),
		.out_data({dr_idx, dr_be_n, dr_data}),
		.level(lvl)
	);

	// flow-through read path
	assign DQ_OUT = s_ff.mem[cur_idx]; // R13
	assign DQ_OE_N = !(s_ff.op == OP_READ) || OUTPUT_ENABLE_N
		|| s_ff.hiz; // R9
	assign HREADYOUT = 1'b1;
	assign HRESP = HRESP_OKAY[0];
	assign HRDATA = s_ff.rdata;

	always_comb begin
		nxt_s = s_ff;
		if (run) begin // R7
			if (!ADVANCE_NOT_LOAD) begin // R2
				nxt_s.cnt = CNT_ZERO;
				nxt_s.base = ADDR;
				nxt_s.ilv = BURST_ORDER_SELECT_N;
				nxt_s.be_n = BYTE_WRITE_ENABLE_N;
				if (!selected)
					nxt_s.op = OP_DESEL; // R8
				else if (!READ_NOT_WRITE)
					nxt_s.op = OP_WRITE; // R4
				else
					nxt_s.op = OP_READ;
			end else if (s_ff.op != OP_DESEL) begin // R3
				nxt_s.cnt = s_ff.cnt + CNT_ONE; // R1
				nxt_s.be_n = BYTE_WRITE_ENABLE_N; // R6
			end
			if (wr_valid && !WRITE_READY)
				nxt_s.drops = s_ff.drops + 8'h01;
		end
		if (dr_valid && dr_ready) begin
			for (int b = 0; b < BE_W; b++) begin
				if (!dr_be_n[b]) // R5
					nxt_s.mem[dr_idx][b*LANE_W +: LANE_W] =
						dr_data[b*LANE_W +: LANE_W];
			end
		end
		if (!TEST_RESET_N)
			nxt_s.tap_rst = 1'b1; // R12
		// register slave
		nxt_s.dwr = 1'b0;
		if (s_ff.dwr && s_ff.daddr == CTRL_OFS) begin
			nxt_s.hold = HWDATA[CTRL_HOLD_BIT];
			nxt_s.hiz = HWDATA[CTRL_HIZ_BIT];
		end
		if (HSEL && HREADY && HTRANS[1]) begin
			nxt_s.dwr = HWRITE;
			nxt_s.daddr = HADDR[7:0];
			nxt_s.rdata = WORD_ZERO;
			if (HADDR[7:0] == CTRL_OFS) begin
				nxt_s.rdata[CTRL_HOLD_BIT] = s_ff.hold;
				nxt_s.rdata[CTRL_HIZ_BIT] = s_ff.hiz;
			end else if (HADDR[7:0] == STAT_OFS) begin
				nxt_s.rdata[STAT_OP_LSB +: 3] = s_ff.op;
				nxt_s.rdata[STAT_CNT_LSB +: 2] = s_ff.cnt;
				nxt_s.rdata[STAT_TAP_BIT] = s_ff.tap_rst;
				nxt_s.rdata[STAT_LVL_LSB +: LW] = lvl;
				nxt_s.rdata[STAT_DROP_LSB +: 8] = s_ff.drops;
			end
		end
	end

	always_ff @(posedge CLK or negedge RESETN) begin
		if (!RESETN) begin
			s_ff <= '0;
			s_ff.op <= OP_DESEL;
			s_ff.tap_rst <= 1'b1; // R12
			s_ff.drops <= DROP_ZERO;
		end else begin
			s_ff <= nxt_s;
		end
	end

	// ========================================
	// assertions
	default clocking cb @(posedge CLK); endclocking
	default disable iff (!RESETN);

	sequence load_sel_s;
		run && !ADVANCE_NOT_LOAD && selected;
	endsequence
	sequence advance_s;
		run && ADVANCE_NOT_LOAD && s_ff.op != OP_DESEL;
	endsequence

	burst_step_a: assert property (advance_s |=> // R1
		s_ff.cnt == $past(s_ff.cnt) + CNT_ONE
		&& s_ff.base[AW-1:2] == $past(s_ff.base[AW-1:2]))
		else $error("burst moved upper address bits");
	load_restart_a: assert property (run && !ADVANCE_NOT_LOAD |=> // R2
		s_ff.cnt == CNT_ZERO && s_ff.base == $past(ADDR))
		else $error("load did not restart burst");
	dir_fixed_a: assert property (advance_s |=> // R3
		s_ff.op == $past(s_ff.op))
		else $error("burst direction changed");
	write_start_a: assert property (load_sel_s ##0 !READ_NOT_WRITE // R4
		|=> s_ff.op == OP_WRITE && DQ_OE_N)
		else $error("write not started");
	suspend_hold_a: assert property (CLOCK_ENABLE_N |=> // R7
		$stable(s_ff.op) && $stable(s_ff.cnt) && $stable(s_ff.base))
		else $error("state moved during suspend");
	desel_a: assert property (run && !ADVANCE_NOT_LOAD && !selected // R8
		|=> s_ff.op == OP_DESEL)
		else $error("deselect not taken");
	bus_release_a: assert property (s_ff.op == OP_DESEL |-> DQ_OE_N) // R9
		else $error("bus driven while deselected");
	pend_read_a: assert property (load_sel_s ##0 READ_NOT_WRITE // R10
		##1 (run && !ADVANCE_NOT_LOAD && !selected) |->
		s_ff.op == OP_READ ##1 DQ_OE_N)
		else $error("pending read lost on deselect");
	select_pol_a: assert property (run && !ADVANCE_NOT_LOAD // R11
		&& !CHIP_SELECT_POSITIVE |=> s_ff.op == OP_DESEL)
		else $error("positive enable polarity wrong");
	tap_reset_a: assert property (!TEST_RESET_N |=> s_ff.tap_rst) // R12
		else $error("test port not in reset");
	flow_read_a: assert property (load_sel_s ##0 READ_NOT_WRITE |=> // R13
		DQ_OUT == s_ff.mem[$past(ADDR[MAW-1:0])]
		&& DQ_OE_N == (OUTPUT_ENABLE_N || s_ff.hiz))
		else $error("read data not flow-through");
	be_lane_a: assert property (dr_valid && dr_ready && dr_be_n[1] |=> // R5
		s_ff.mem[$past(dr_idx)][DATA_W-1:LANE_W]
		== $past(s_ff.mem[dr_idx][DATA_W-1:LANE_W]))
		else $error("masked byte lane written");
	drop_count_a: assert property (wr_valid && !WRITE_READY |=>
		s_ff.drops == $past(s_ff.drops) + 8'h01)
		else $error("dropped write not counted");
endmodule

// file: test/sram_ctrl_model.sv
// memory controller model driving the sram pins
`timescale 1ns/100ps
// ========================================
// controller
module sram_ctrl_model (
	// clock
	input wire logic clk,
	// address and control
	output logic [19:0] addr,
	output logic rnw,
	output logic anl,
	output logic ilv,
	output logic cen_n,
	output logic [1:0] be_n,
	output logic [2:0] cs,
	// write data
	output logic [17:0] dq
);
	logic wr = 1'b0;
	logic pend = 1'b0;
	logic [17:0] nxt = 18'h0;
	initial {addr, rnw, anl, ilv, cen_n, be_n, cs, dq} = 47'h1C0000;
	// one effective edge: load or advance
	task automatic cyc(input logic ld, r, i, input logic [2:0] c,
		input logic [19:0] a, input logic [1:0] b, input logic [17:0] d);
		cen_n <= 1'b0;
		anl <= ~ld;
		rnw <= r;
		ilv <= i;
		cs <= c;
		addr <= a;
		be_n <= b;
		dq <= pend ? nxt : ~dq;
		wr <= ld ? ~r & (c == 3'h1) : wr;
		pend <= ld ? ~r & (c == 3'h1) : wr;
		nxt <= d;
		@(posedge clk);
	endtask
	// one suspended edge
	task automatic hold();
		cen_n <= 1'b1;
		@(posedge clk);
	endtask
endmodule

// file: test/testbench.sv
// self-checking bench for the sram bus interface
`timescale 1ns/100ps
// ========================================
// bench
module testbench;
	import sram_bus_pkg::*;
	logic CLK = 1'b0;
	logic RESETN = 1'b0;
	logic [19:0] ADDR;
	logic RNW, ANL, ILV, CEN_N, DQ_OE_N, WRITE_READY, HREADYOUT, HRESP;
	logic [1:0] BE_N;
	logic [2:0] CS;
	logic [17:0] DQ_IN, DQ_OUT;
	logic HSEL = 1'b0;
	logic TEST_RESET_N = 1'b0;
	logic HWRITE = 1'b0;
	logic [1:0] HTRANS = 2'h0;
	logic [31:0] HADDR = 32'h0, HWDATA = 32'h0, HRDATA, r;
	logic [17:0] mem [16];
	logic [17:0] expq [$];
	int seed = 32'h3380;
	int n_fail = 0;
	int checks = 0;
	always #25 CLK = ~CLK;
	sram_ctrl_model i_ctrl (.clk(CLK), .addr(ADDR), .rnw(RNW), .anl(ANL),
		.ilv(ILV), .cen_n(CEN_N), .be_n(BE_N), .cs(CS), .dq(DQ_IN));
	sram_bus_if i_dut (.CLK(CLK), .RESETN(RESETN), .ADDR(ADDR),
		.READ_NOT_WRITE(RNW), .ADVANCE_NOT_LOAD(ANL),
		.BURST_ORDER_SELECT_N(ILV), .CLOCK_ENABLE_N(CEN_N),
		.BYTE_WRITE_ENABLE_N(BE_N), .CHIP_SELECT_FIRST_N(CS[2]),
		.CHIP_SELECT_SECOND_N(CS[1]), .CHIP_SELECT_POSITIVE(CS[0]),
		.OUTPUT_ENABLE_N(1'b0), .TEST_RESET_N(TEST_RESET_N), .DQ_IN(DQ_IN),
		.DQ_OUT(DQ_OUT), .DQ_OE_N(DQ_OE_N), .WRITE_READY(WRITE_READY),
		.HSEL(HSEL), .HADDR(HADDR), .HTRANS(HTRANS), .HWRITE(HWRITE),
		.HSIZE(3'h2), .HWDATA(HWDATA), .HREADY(HREADYOUT),
		.HREADYOUT(HREADYOUT), .HRESP(HRESP), .HRDATA(HRDATA));
	// ========================================
	// checking and closing
	task automatic chk(input logic [31:0] g, e);
		checks++;
		if (g !== e) begin
			n_fail++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	task automatic complete_run();
		$display("checks=%0d n_fail=%0d", checks, n_fail);
		if (n_fail == 0 && checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	always @(negedge CLK)
		if (RESETN && DQ_OE_N === 1'b0 && CEN_N === 1'b0 && expq.size() > 0)
			chk({14'h0, DQ_OUT}, {14'h0, expq.pop_front()});
	// ========================================
	// bus and pin tasks
	task automatic rdy();
		int n;
		n = 0;
		do begin
			@(posedge CLK);
			n++;
		end while (HREADYOUT !== 1'b1 && n < 99);
		if (n >= 99) begin
			n_fail++;
			complete_run();
		end
	endtask
	task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
		HSEL <= 1'b1;
		HTRANS <= 2'h2;
		HWRITE <= w;
		HADDR <= {24'h0, a};
		rdy();
		HTRANS <= 2'h0;
		HWDATA <= d;
		rdy();
		r = HRDATA;
		chk({31'h0, HRESP}, 32'h0);
	endtask
	task automatic bst(input logic rd, input logic [2:0] c, input logic [3:0] b,
		input logic i, input int len, input logic [1:0] be, input logic st);
		logic [3:0] a;
		logic [17:0] d;
		for (int k = 0; k < len; k++) begin
			a = {b[3:2], i ? b[1:0] ^ 2'(k) : b[1:0] + 2'(k)};
			d = 18'($random(seed));
			if (c == 3'h1 && rd)
				expq.push_back(mem[a]);
			if (c == 3'h1 && !rd && !be[0])
				mem[a][8:0] = d[8:0];
			if (c == 3'h1 && !rd && !be[1])
				mem[a][17:9] = d[17:9];
			i_ctrl.cyc(k == 0, k ? 1'($random(seed)) : rd, i, c, 20'(b), be, d);
			if (st)
				i_ctrl.hold();
		end
	endtask
	// ========================================
	// main sequence
	initial begin
		repeat (10) @(posedge CLK);
		RESETN <= 1'b1;
		ahb(1'b0, STAT_OFS, 32'h0);
		chk(r, 32'h41);
		ahb(1'b0, 8'h08, 32'h0);
		chk(r, 32'h0);
		TEST_RESET_N <= 1'b1;
		$display("test regs done");
		bst(1'b0, 3'h1, 4'h0, 1'b0, 4, 2'h0, 1'b0);
		bst(1'b0, 3'h1, 4'h5, 1'b1, 4, 2'h0, 1'b1);
		bst(1'b0, 3'h1, 4'h8, 1'b0, 4, 2'h0, 1'b0);
		bst(1'b0, 3'h1, 4'h9, 1'b0, 1, 2'h2, 1'b0);
		bst(1'b1, 3'h6, 4'h0, 1'b0, 2, 2'h3, 1'b0);
		bst(1'b1, 3'h1, 4'h2, 1'b1, 4, 2'h3, 1'b0);
		bst(1'b1, 3'h1, 4'h9, 1'b0, 4, 2'h3, 1'b1);
		bst(1'b1, 3'h1, 4'h6, 1'b0, 2, 2'h3, 1'b0);
		$display("test bursts done");
		for (int i = 0; i < 3; i++) begin
			bst(1'b1, 3'h1, 4'h4, 1'b1, 1, 2'h3, 1'b0);
			bst(1'b1, 3'h1 ^ (3'h1 << i), 4'h0, 1'b0, 1, 2'h3, 1'b0);
			#1 chk({31'h0, DQ_OE_N}, 32'h1);
		end
		ahb(1'b1, CTRL_OFS, 32'h2);
		bst(1'b1, 3'h1, 4'h4, 1'b1, 1, 2'h3, 1'b0);
		#1 chk({31'h0, DQ_OE_N}, 32'h1);
		void'(expq.pop_back());
		bst(1'b1, 3'h6, 4'h0, 1'b0, 1, 2'h3, 1'b0);
		$display("test deselect done");
		ahb(1'b1, CTRL_OFS, 32'h1);
		bst(1'b0, 3'h1, 4'hC, 1'b0, 9, 2'h0, 1'b0);
		bst(1'b1, 3'h6, 4'h0, 1'b0, 1, 2'h3, 1'b0);
		#1 chk({31'h0, WRITE_READY}, 32'h0);
		ahb(1'b0, STAT_OFS, 32'h0);
		chk(r & 32'hFFFF0F00, 32'h10800);
		ahb(1'b1, CTRL_OFS, 32'h0);
		bst(1'b1, 3'h6, 4'h0, 1'b0, 12, 2'h3, 1'b0);
		#1 chk({31'h0, WRITE_READY}, 32'h1);
		chk(32'(expq.size()), 32'h0);
		$display("test fifo done");
		complete_run();
	end
endmodule
